//--- hdl/octal_uart_host_bus_port.sv
// Function
// RQ1 - Address bits 3:0 pick one of sixteen channel registers.
// RQ2 - Address bits 6:4 pick the channel zero to seven.
// RQ3 - Address bit 7 selects global registers instead of channel registers.
// RQ4 - Eight-bit data bus, driven on reads, sampled on writes.
// RQ5 - Split mode: read strobe falling edge starts read, byte driven.
// RQ6 - Split mode: write strobe falling starts write, rising edge stores byte.
// RQ7 - Split mode: bus cycles only honoured while chip select low.
// RQ8 - Single mode: host ties read strobe high.
// RQ9 - Single mode: write strobe pin is direction, high read, low write.
// RQ10 - Single mode: chip select is the sole active-low strobe.
// RQ11 - All channel interrupts merge onto one open-drain active-low line.
// RQ12 - Receive idles high; feature bit 4 inverts infrared receive.
// RQ13 - Request-to-send serves flow control or RS485 direction via feature bit 5.
// RQ14 - Clear-to-send gates transmit when enhanced bit 7 set.
// RQ15 - Terminal-ready carries flow control via enhanced bit 6 or RS485.
// RQ16 - Per-channel 64-byte FIFO levels and trigger levels readable.
// RQ17 - Data drivers released whenever no qualified read is in progress.
module octal_uart_host_bus_port
    import uart_port_pkg::*;
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    // Host bus
    input  wire logic                       bus_style,
    input  wire logic                       read_strobe_n,
    input  wire logic                       write_strobe_n,
    input  wire logic                       chip_sel_n,
    input  wire logic [uart_port_pkg::ADDR_W-1:0] host_addr,
    input  wire logic [uart_port_pkg::DATA_W-1:0] host_data_in,
    output logic [uart_port_pkg::DATA_W-1:0] host_data_out,
    output logic                            host_data_oe,
    // Interrupt, open drain
    input  wire logic [uart_port_pkg::NUM_CHAN-1:0] chan_irq,
    output logic                            irq_out,
    output logic                            irq_oe,
    // FIFO status from the datapath
    input  wire logic [uart_port_pkg::NUM_CHAN*uart_port_pkg::LVL_W-1:0] tx_level,
    input  wire logic [uart_port_pkg::NUM_CHAN*uart_port_pkg::LVL_W-1:0] rx_level,
    output logic [uart_port_pkg::NUM_CHAN-1:0] rx_trig_hit,
    // Serial flow control pins
    input  wire logic [uart_port_pkg::NUM_CHAN-1:0] serial_rx,
    input  wire logic [uart_port_pkg::NUM_CHAN-1:0] clear_to_send_n,
    input  wire logic [uart_port_pkg::NUM_CHAN-1:0] tx_busy,
    output logic [uart_port_pkg::NUM_CHAN-1:0] rx_decoded,
    output logic [uart_port_pkg::NUM_CHAN-1:0] tx_allow,
    output logic [uart_port_pkg::NUM_CHAN-1:0] request_to_send_n,
    output logic [uart_port_pkg::NUM_CHAN-1:0] terminal_ready_n
);
    import uart_port_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int PIN_W = 4 + ADDR_W + DATA_W + 2 * NUM_CHAN;
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] raw;

    assign raw = {bus_style, read_strobe_n, write_strobe_n, chip_sel_n,
                  host_addr, host_data_in, serial_rx, clear_to_send_n};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1   <= {PIN_W{1'b1}};
            s2   <= {PIN_W{1'b1}};
            s3   <= {PIN_W{1'b1}};
            pins <= {PIN_W{1'b1}};
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < PIN_W; i++) begin
                if (s2[i] == s3[i]) begin
                    pins[i] <= s3[i];
                end
            end
        end
    end

    logic                bs_q;
    logic                rd_n_q;
    logic                wr_n_q;
    logic                cs_n_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   din_q;
    logic [NUM_CHAN-1:0] rx_q;
    logic [NUM_CHAN-1:0] cts_n_q;

    assign {bs_q, rd_n_q, wr_n_q, cs_n_q, addr_q, din_q, rx_q, cts_n_q} = pins;

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    host_access_if acc ();
    logic read_active;

    strobe_decode u_dec (
        .sys_clk     (sys_clk),
        .arst_n      (arst_n),
        .bus_style   (bs_q),
        .rd_n        (rd_n_q),
        .wr_n        (wr_n_q),
        .cs_n        (cs_n_q),
        .addr        (addr_q),
        .din         (din_q),
        .acc         (acc.port),
        .read_active (read_active)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [DATA_W-1:0] regs [NUM_CHAN][NUM_REG];
    logic [DATA_W-1:0] gregs [NUM_REG];

    function automatic logic [LVL_W-1:0] lvl_of(input logic [NUM_CHAN*LVL_W-1:0] v,
                                                input logic [CHAN_W-1:0] c);
        lvl_of = v[c*LVL_W +: LVL_W];
    endfunction

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                for (int r = 0; r < NUM_REG; r++) begin
                    regs[c][r] <= (r == int'(IDX_TRIG)) ? {1'b0, TRIG_RESET} : REG_RESET;
                end
            end
            for (int r = 0; r < NUM_REG; r++) begin
                gregs[r] <= REG_RESET;
            end
        end else if (acc.wr_pulse) begin
            if (acc.global_sel) begin // RQ3
                gregs[acc.idx] <= acc.wdata; // RQ4
            end else begin
                regs[acc.chan][acc.idx] <= acc.wdata; // RQ1 RQ2 RQ6
            end
        end
    end

    // Global index 0 reads the combined interrupt source
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        if (acc.global_sel) begin
            rd_mux = (acc.idx == 4'h0) ? chan_irq : gregs[acc.idx];
        end else begin
            case (acc.idx)
                IDX_TXLVL: rd_mux = {1'b0, lvl_of(tx_level, acc.chan)}; // RQ16
                IDX_RXLVL: rd_mux = {1'b0, lvl_of(rx_level, acc.chan)}; // RQ16
                default:   rd_mux = regs[acc.chan][acc.idx];
            endcase
        end
    end
    assign acc.rdata = rd_mux;

    // ------------------------------------------------------------
    // Data bus drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_data_out <= 8'h00;
        end else if (acc.rd_pulse) begin
            host_data_out <= acc.rdata; // RQ5
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_data_oe <= 1'b0;
        end else begin
            host_data_oe <= read_active; // RQ4 RQ17
        end
    end

    // ------------------------------------------------------------
    // Interrupt merge
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_oe <= 1'b0;
        end else begin
            irq_oe <= |chan_irq; // RQ11
        end
    end
    assign irq_out = 1'b0;

    // ------------------------------------------------------------
    // Per-channel serial control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_decoded        <= '1;
            tx_allow          <= '1;
            request_to_send_n <= '1;
            terminal_ready_n  <= '1;
            rx_trig_hit       <= '0;
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                // Inversion applied ahead of the decoder
                rx_decoded[c] <= rx_q[c] ^ regs[c][IDX_FEATURE][FEAT_IR_INV]; // RQ12
                tx_allow[c]   <= !(regs[c][IDX_ENH_FEAT][ENH_AUTO_CTS] && cts_n_q[c]); // RQ14
                rx_trig_hit[c] <= lvl_of(rx_level, CHAN_W'(c)) >= regs[c][IDX_TRIG][LVL_W-1:0]; // RQ16
                if (regs[c][IDX_FEATURE][FEAT_RS485]) begin
                    // Half duplex: assert while transmitting
                    request_to_send_n[c] <= !tx_busy[c]; // RQ13
                    terminal_ready_n[c]  <= !tx_busy[c]; // RQ15
                end else if (regs[c][IDX_ENH_FEAT][ENH_AUTO_RTS]) begin
                    request_to_send_n[c] <= lvl_of(rx_level, CHAN_W'(c))
                                            >= regs[c][IDX_TRIG][LVL_W-1:0]; // RQ13
                    terminal_ready_n[c]  <= lvl_of(rx_level, CHAN_W'(c))
                                            >= regs[c][IDX_TRIG][LVL_W-1:0]; // RQ15
                end else begin
                    request_to_send_n[c] <= !regs[c][IDX_MODEM_CTRL][MODEM_RTS];
                    terminal_ready_n[c]  <= !regs[c][IDX_MODEM_CTRL][MODEM_DTR];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_oe_follows_read : assert property (@(posedge sys_clk) disable iff (!arst_n)
        !read_active |=> !host_data_oe) else $error("bus driven without read"); // RQ17
    a_irq_merge : assert property (@(posedge sys_clk) disable iff (!arst_n)
        (chan_irq != '0) |=> irq_oe) else $error("interrupt not driven"); // RQ11
    a_irq_release : assert property (@(posedge sys_clk) disable iff (!arst_n)
        (chan_irq == '0) |=> !irq_oe) else $error("interrupt held"); // RQ11
    a_read_data : assert property (@(posedge sys_clk) disable iff (!arst_n)
        acc.rd_pulse |=> host_data_out == $past(acc.rdata)) else $error("read data wrong"); // RQ5
    a_write_store : assert property (@(posedge sys_clk) disable iff (!arst_n)
        acc.wr_pulse && !acc.global_sel |=> regs[$past(acc.chan)][$past(acc.idx)] == $past(acc.wdata))
        else $error("write not stored"); // RQ6
    a_global_store : assert property (@(posedge sys_clk) disable iff (!arst_n)
        acc.wr_pulse && acc.global_sel |=> gregs[$past(acc.idx)] == $past(acc.wdata))
        else $error("global write lost"); // RQ3
    a_cts_gate : assert property (@(posedge sys_clk) disable iff (!arst_n)
        regs[0][IDX_ENH_FEAT][ENH_AUTO_CTS] && cts_n_q[0] |=> !tx_allow[0]) else $error("cts gate open"); // RQ14
    a_ir_invert : assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> rx_decoded[0] == ($past(rx_q[0]) ^ $past(regs[0][IDX_FEATURE][FEAT_IR_INV])))
        else $error("rx inversion wrong"); // RQ12
endmodule // octal_uart_host_bus_port

//--- hdl/uart_port_pkg.sv
package uart_port_pkg;
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 8;
    localparam int REG_IDX_W   = 4;
    localparam int CHAN_W      = 3;
    localparam int NUM_CHAN    = 8;
    localparam int NUM_REG     = 16;
    localparam int REG_LSB     = 0;
    localparam int CHAN_LSB    = 4;
    localparam int GLOBAL_BIT  = 7;
    // ------------------------------------------------------------
    // Register indices and bits
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_MODEM_CTRL = 4'h4;
    localparam logic [3:0] IDX_FEATURE    = 4'h8;
    localparam logic [3:0] IDX_ENH_FEAT   = 4'h9;
    localparam logic [3:0] IDX_TXLVL = 4'ha;
    localparam logic [3:0] IDX_RXLVL = 4'hb;
    localparam logic [3:0] IDX_TRIG = 4'hc;
    localparam int FEAT_IR_INV  = 4;
    localparam int FEAT_RS485   = 5;
    localparam int ENH_AUTO_RTS = 6;
    localparam int ENH_AUTO_CTS = 7;
    localparam int MODEM_RTS    = 1;
    localparam int MODEM_DTR    = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FIFO_DEPTH   = 64;
    localparam int LVL_W        = 7;
    localparam logic [6:0] TRIG_RESET = 7'h20;
    typedef enum logic {BUS_SPLIT, BUS_SINGLE} bus_mode_t;
endpackage

//--- hdl/host_access_if.sv
interface host_access_if;
    import uart_port_pkg::*;
    logic                 rd_pulse;
    logic                 wr_pulse;
    logic                 global_sel;
    logic [CHAN_W-1:0]    chan;
    logic [REG_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    wdata;
    logic [DATA_W-1:0]    rdata;
    modport port (output rd_pulse, wr_pulse, global_sel, chan, idx, wdata, input rdata);
    modport regs (input rd_pulse, wr_pulse, global_sel, chan, idx, wdata, output rdata);
endinterface

//--- hdl/strobe_decode.sv
module strobe_decode
    import uart_port_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // Synchronised pins
    input  wire logic              bus_style,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic              cs_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] din,
    // Decoded access
    host_access_if.port            acc,
    output logic                   read_active
);
    logic rd_act;
    logic wr_act;
    logic rd_q;
    logic wr_q;

    always_comb begin
        if (bus_style) begin
            rd_act = !cs_n && !rd_n; // RQ5 RQ7
            wr_act = !cs_n && !wr_n; // RQ6 RQ7
        end else begin
            rd_act = !cs_n && wr_n;  // RQ9 RQ10
            wr_act = !cs_n && !wr_n; // RQ9 RQ10
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
        end
    end

    assign acc.rd_pulse   = rd_act && !rd_q;          // RQ5
    assign acc.wr_pulse   = !wr_act && wr_q;          // RQ6
    assign acc.global_sel = addr[GLOBAL_BIT];         // RQ3
    assign acc.chan       = addr[CHAN_LSB +: CHAN_W]; // RQ2
    assign acc.idx        = addr[REG_LSB +: REG_IDX_W]; // RQ1
    assign acc.wdata      = din;
    assign read_active    = rd_act;                   // RQ17

    a_read_edge : assert property (@(posedge sys_clk) disable iff (!arst_n)
        acc.rd_pulse |=> !acc.rd_pulse) else $error("read pulse too long"); // RQ5
    a_no_cs_no_wr : assert property (@(posedge sys_clk) disable iff (!arst_n)
        cs_n && $past(cs_n) |-> !acc.wr_pulse) else $error("write without select"); // RQ7
endmodule // strobe_decode

//--- tb/host_cpu_model.sv
module host_cpu_model
(
    // Clock and strap
    input  wire logic                             sys_clk,
    input  wire logic                             bus_style,
    // Host bus pins
    output logic                                  read_strobe_n,
    output logic                                  write_strobe_n,
    output logic                                  chip_sel_n,
    output logic [uart_port_pkg::ADDR_W-1:0]      host_addr,
    output logic [uart_port_pkg::DATA_W-1:0]      host_data_in,
    input  wire logic [uart_port_pkg::DATA_W-1:0] host_data_out,
    input  wire logic                             host_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import uart_port_pkg::*;
    logic              drive = 1'b0;
    logic [DATA_W-1:0] wdat  = 8'h00;
    logic [DATA_W-1:0] last  = 8'h00;
    // ------------------------------------------------------------
    // Wire level: device, host, or a value that changes every cycle
    // ------------------------------------------------------------
    assign host_data_in = host_data_oe ? host_data_out : (drive ? wdat : ~last);
    always @(posedge sys_clk) begin
        last <= host_data_in;
    end
    initial begin
        read_strobe_n  = 1'b1;
        write_strobe_n = 1'b1;
        chip_sel_n     = 1'b1;
        host_addr      = 8'h00;
    end
    // One byte; seen reports whether the device drove the bus
    task automatic access(input logic wr, input logic sel, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic seen);
        @(negedge sys_clk);
        host_addr      = a;
        wdat           = d;
        drive          = wr;
        chip_sel_n     = ~sel;
        read_strobe_n  = bus_style ? wr : 1'b1;
        write_strobe_n = ~wr;
        q    = 8'h00;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            if (host_data_oe === 1'b1 && !seen) begin
                q    = host_data_out;
                seen = 1'b1;
            end
        end
        @(negedge sys_clk);
        chip_sel_n     = 1'b1;
        read_strobe_n  = 1'b1;
        write_strobe_n = 1'b1;
        repeat (7) @(negedge sys_clk);
        drive = 1'b0;
    endtask
endmodule // host_cpu_model

//--- tb/test_octal_uart_host_bus_port.sv
module test_octal_uart_host_bus_port;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_port_pkg::*;
    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        bus_style = 1'b1;
    logic        rs_n, ws_n, cs_n, hoe, irq_out, irq_oe;
    logic [7:0]  addr, hdi, hdo, trig_hit, rx_dec, tx_allow, rts_n, dtr_n;
    logic [7:0]  chan_irq = 8'h00;
    logic [7:0]  serial_rx = 8'hff;
    logic [7:0]  cts_n = 8'hff;
    logic [7:0]  tx_busy = 8'h00;
    logic [55:0] tx_level, rx_level;
    logic        irq_line;
    int          num_errors = 0;
    int          n_compared = 0;
    // ------------------------------------------------------------
    // Clock, pull-up, units
    // ------------------------------------------------------------
    always #25 sys_clk = ~sys_clk;
    assign irq_line = irq_oe ? irq_out : 1'b1;
    host_cpu_model host (.sys_clk(sys_clk), .bus_style(bus_style), .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .chip_sel_n(cs_n), .host_addr(addr), .host_data_in(hdi),
        .host_data_out(hdo), .host_data_oe(hoe));
    octal_uart_host_bus_port uut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_style(bus_style),
        .read_strobe_n(rs_n), .write_strobe_n(ws_n), .chip_sel_n(cs_n), .host_addr(addr),
        .host_data_in(hdi), .host_data_out(hdo), .host_data_oe(hoe), .chan_irq(chan_irq),
        .irq_out(irq_out), .irq_oe(irq_oe), .tx_level(tx_level), .rx_level(rx_level),
        .rx_trig_hit(trig_hit), .serial_rx(serial_rx), .clear_to_send_n(cts_n), .tx_busy(tx_busy),
        .rx_decoded(rx_dec), .tx_allow(tx_allow), .request_to_send_n(rts_n), .terminal_ready_n(dtr_n));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic sel = 1'b1);
        logic [7:0] q;
        logic       seen;
        host.access(1'b0, sel, a, 8'h00, q, seen);
        check({6'h00, hoe, seen, q}, {7'h00, sel, sel ? exp : 8'h00});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel = 1'b1);
        logic [7:0] q;
        logic       seen;
        host.access(1'b1, sel, a, d, q, seen);
        check({14'h0000, hoe, seen}, 16'h0000);
    endtask
    task automatic settle();
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rx_level = '0;
        for (int c = 0; c < 8; c++) tx_level[c*7 +: 7] = 7'(c * 5 + 3);
        repeat (10) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({hoe, irq_oe, 6'h00, trig_hit}, 16'h0000);
        check({tx_allow, rx_dec}, 16'hffff);
        check({rts_n, dtr_n}, 16'hffff);
        rd(8'h0c, 8'h20);
        for (int c = 0; c < 8; c++) begin
            wr({1'b0, 3'(c), IDX_FEATURE}, 8'({c[0], 1'b0, c[2:0]}));
            rd({1'b0, 3'(c), IDX_TXLVL}, 8'(c * 5 + 3));
        end
        wr(8'h88, 8'h5a);
        rd(8'h88, 8'h5a);
        for (int c = 0; c < 8; c++) rd({1'b0, 3'(c), IDX_FEATURE}, 8'({c[0], 1'b0, c[2:0]}));
        settle();
        check({8'h00, rx_dec}, 16'h0055);
        chan_irq = 8'h24;
        settle();
        check({15'h0000, irq_line}, 16'h0000);
        rd(8'h80, 8'h24);
        chan_irq = 8'h00;
        settle();
        check({15'h0000, irq_line}, 16'h0001);
        wr(8'h08, 8'hee, 1'b0);
        rd(8'h08, 8'h00, 1'b0);
        rd(8'h08, 8'h00);
        wr(8'h19, 8'h80);
        cts_n = 8'h06;
        settle();
        check({8'h00, tx_allow}, 16'h00fd);
        wr(8'h48, 8'h20);
        tx_busy = 8'h10;
        settle();
        check({rts_n, dtr_n}, 16'hefef);
        tx_busy = 8'h00;
        wr(8'h34, 8'h03);
        wr(8'h39, 8'h40);
        rx_level[21 +: 7] = 7'h1f;
        settle();
        check({trig_hit, rts_n | dtr_n}, 16'h00f7);
        rx_level[21 +: 7] = 7'h20;
        settle();
        check({trig_hit, rts_n | dtr_n}, 16'h08ff);
        rd(8'h3b, 8'h20);
        bus_style = 1'b0;
        settle();
        wr(8'h83, 8'hc3);
        rd(8'h83, 8'hc3);
        wr(8'h83, 8'h11, 1'b0);
        rd(8'h83, 8'hc3);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        tally_and_finish();
    end
endmodule // test_octal_uart_host_bus_port
